/* File: rtl/tlic_consts.vh */
`ifndef TLIC_CONSTS_VH
`define TLIC_CONSTS_VH

`define TLIC_NSRC        18
`define TLIC_IDX_W       5
`define TLIC_ADDR_W      8

`define TLIC_OFF_CTRL    8'h00
`define TLIC_OFF_EN      8'h04
`define TLIC_OFF_PRIO    8'h08
`define TLIC_OFF_PSET    8'h0C
`define TLIC_OFF_PCLR    8'h10
`define TLIC_OFF_STAT    8'h14
`define TLIC_OFF_IST     8'h18
`define TLIC_OFF_IMASK   8'h1C

`define TLIC_CTRL_GEN    0
`define TLIC_IST_CALL    0
`define TLIC_IST_RET     1
`define TLIC_IST_W       2

`define TLIC_RST_CTRL    1'h0
`define TLIC_RST_EN      18'h00000
`define TLIC_RST_PRIO    18'h00000
`define TLIC_RST_PEND    18'h00000

`define TLIC_VEC_BASE    16'h0003
`define TLIC_VEC_STEP    16'h0008
`define TLIC_HWCLR_MASK  18'h1000F

`define TLIC_DETECT_CYC  1
`define TLIC_CALL_CYC    3'h4
`define TLIC_INTERRUPT_RETURN_INSTRUCTION_CYC    5
`define TLIC_DIV_CYC     8
`define TLIC_CNT_W       3

`define TLIC_RESP_OKAY   2'h0
`define TLIC_RESP_SLVERR 2'h2

`endif

/* File: rtl/tlic_top.v */
// Functional notes
// - Eighteen sources, each low or high level
// - Source event sets pending regardless of enable
// - Enabled pending source calls its vector
// - Service routine ends with return; CPU resumes
// - Disabled pending source raises no request
// - Each source has its own enable bit
// - Global enable gates every source enable
// - Stale request may follow enable clear once
// - Some flags auto-clear on vectoring
// - Still-pending flag re-enters after one instruction
// - Software-set pending flag acts like hardware
// - High preempts low; high never preempted
// - Higher level first, then fixed source order
// - Sampled each clock; call after detect cycle
// - Pending at return waits one instruction
// - Equal or higher routine blocks new request
//
// Design decisions made here: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "tlic_consts.vh"

module tlic_top #(
  parameter NSRC = `TLIC_NSRC
) (
  input  wire                     aclk,
  input  wire                     aresetn,
  input  wire [`TLIC_ADDR_W-1:0]  s_axi_awaddr,
  input  wire                     s_axi_awvalid,
  output wire                     s_axi_awready,
  input  wire [31:0]              s_axi_wdata,
  input  wire [3:0]               s_axi_wstrb,
  input  wire                     s_axi_wvalid,
  output wire                     s_axi_wready,
  output reg  [1:0]               s_axi_bresp,
  output reg                      s_axi_bvalid,
  input  wire                     s_axi_bready,
  input  wire [`TLIC_ADDR_W-1:0]  s_axi_araddr,
  input  wire                     s_axi_arvalid,
  output wire                     s_axi_arready,
  output reg  [31:0]              s_axi_rdata,
  output reg  [1:0]               s_axi_rresp,
  output reg                      s_axi_rvalid,
  input  wire                     s_axi_rready,
  input  wire [NSRC-1:0]          src_event,
  input  wire                     instr_done,
  input  wire                     interrupt_return_instruction_done,
  output reg                      call_start,
  output reg  [15:0]              call_vector,
  output reg  [`TLIC_IDX_W-1:0]   call_source,
  output reg                      call_level,
  output wire                     call_busy,
  output wire [1:0]               active_level,
  output wire                     global_irq_enable,
  output wire                     irq
);

  localparam [`TLIC_CNT_W-1:0] CALL_CNT = `TLIC_CALL_CYC;

  // Lowest set index wins: the fixed order inside one level
  function [`TLIC_IDX_W-1:0] tlic_first;
    input [NSRC-1:0] v;
    integer i;
    begin
      tlic_first = {`TLIC_IDX_W{1'b0}};
      for (i = NSRC - 1; i >= 0; i = i - 1) begin
        if (v[i]) begin
          tlic_first = i[`TLIC_IDX_W-1:0];
        end
      end
    end
  endfunction

  function [31:0] tlic_merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    integer b;
    begin
      tlic_merge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b]) begin
          tlic_merge[b*8 +: 8] = nw[b*8 +: 8];
        end
      end
    end
  endfunction

  // One-hot decode of the winner, to pick its hardware-cleared flag
  function [NSRC-1:0] tlic_onehot;
    input [`TLIC_IDX_W-1:0] idx;
    integer k;
    begin
      tlic_onehot = {NSRC{1'b0}};
      for (k = 0; k < NSRC; k = k + 1) begin
        if (idx == k[`TLIC_IDX_W-1:0]) begin
          tlic_onehot[k] = 1'b1;
        end
      end
    end
  endfunction

  reg                     gen_reg;
  reg  [NSRC-1:0]         en_reg;
  reg  [NSRC-1:0]         prio_reg;
  reg  [NSRC-1:0]         pend_reg;
  reg  [NSRC-1:0]         pend_next;
  reg  [`TLIC_IST_W-1:0]  ist_reg;
  reg  [`TLIC_IST_W-1:0]  imask_reg;
  reg  [1:0]              act_reg;
  reg  [1:0]              act_next;
  reg                     req_valid_reg;
  reg  [`TLIC_IDX_W-1:0]  req_idx_reg;
  reg                     req_lvl_reg;
  reg  [`TLIC_CNT_W-1:0]  call_cnt_reg;
  reg                     aw_full_reg;
  reg  [`TLIC_ADDR_W-1:0] aw_addr_reg;
  reg                     w_full_reg;
  reg  [31:0]             w_data_reg;
  reg  [3:0]              w_strb_reg;

  wire                    wr_go;
  wire                    rd_go;
  wire [31:0]             wr_val;
  wire [NSRC-1:0]         elig;
  wire [NSRC-1:0]         hi_req;
  wire [NSRC-1:0]         lo_req;
  wire                    hi_ok;
  wire                    lo_ok;
  wire                    take;
  wire                    ret_ev;
  wire [NSRC-1:0]         sw_set;
  wire [NSRC-1:0]         sw_clr;
  wire [NSRC-1:0]         auto_clr;
  wire [`TLIC_IST_W-1:0]  ist_clr;
  wire [`TLIC_IST_W-1:0]  ist_set;
  reg  [31:0]             rd_val;
  reg                     rd_hit;
  reg                     wr_hit;
  wire [31:0]             en_merged;
  wire [31:0]             prio_merged;
  wire [10:0]             stat_word;
  wire [NSRC-1:0]         hwclr_mask;
  wire                    plain_bnd;

  assign wr_go  = aw_full_reg & w_full_reg & ~s_axi_bvalid;
  assign rd_go  = s_axi_arvalid & ~s_axi_rvalid;
  assign wr_val = tlic_merge(32'h00000000, w_data_reg, w_strb_reg);

  assign s_axi_awready = ~aw_full_reg;
  assign s_axi_wready  = ~w_full_reg;
  assign s_axi_arready = ~s_axi_rvalid;

  // Byte lanes merge into the 18-bit enable and priority words
  assign en_merged   = tlic_merge({{(32-NSRC){1'b0}}, en_reg}, w_data_reg, w_strb_reg);
  assign prio_merged = tlic_merge({{(32-NSRC){1'b0}}, prio_reg}, w_data_reg, w_strb_reg);
  // Bit 5 of the status word is spare
  assign stat_word   = {call_busy, act_reg, req_lvl_reg, req_valid_reg, 1'b0, req_idx_reg};
  assign hwclr_mask  = `TLIC_HWCLR_MASK;

  // Flags are visible even while masked; only the request path is gated
  assign elig   = pend_reg & en_reg & {NSRC{gen_reg}};
  assign hi_req = elig & prio_reg;
  assign lo_req = elig & ~prio_reg;
  // A running high routine blocks everything, a low one blocks low.
  // Levels are judged as they stand after this edge, so a return
  // frees the very next boundary and a take blocks at once.
  assign hi_ok  = ~act_next[1];
  assign lo_ok  = (act_next == 2'b00);

  // The return boundary itself never vectors: one instruction runs first
  assign plain_bnd = instr_done & ~interrupt_return_instruction_done;
  assign take = plain_bnd & req_valid_reg & ~call_busy;
  assign ret_ev = instr_done & interrupt_return_instruction_done & (act_reg != 2'b00);

  assign call_busy         = (call_cnt_reg != {`TLIC_CNT_W{1'b0}});
  assign active_level      = act_reg;
  assign global_irq_enable = gen_reg;
  assign irq               = |(ist_reg & imask_reg);

  assign sw_set = (wr_go && aw_addr_reg == `TLIC_OFF_PSET) ?
                  wr_val[NSRC-1:0] : {NSRC{1'b0}};
  assign sw_clr = (wr_go && aw_addr_reg == `TLIC_OFF_PCLR) ?
                  wr_val[NSRC-1:0] : {NSRC{1'b0}};
  assign auto_clr = take ? (tlic_onehot(req_idx_reg) & hwclr_mask) :
                    {NSRC{1'b0}};
  assign ist_clr = (wr_go && aw_addr_reg == `TLIC_OFF_IST) ?
                   wr_val[`TLIC_IST_W-1:0] : {`TLIC_IST_W{1'b0}};
  assign ist_set = {ret_ev, take};

  always @* begin
    // New events win over any clear in the same cycle
    pend_next = (pend_reg & ~sw_clr & ~auto_clr) | src_event | sw_set;
  end

  always @* begin
    act_next = act_reg;
    if (ret_ev) begin
      if (act_reg[1]) begin
        act_next[1] = 1'b0;
      end else begin
        act_next[0] = 1'b0;
      end
    end
    if (take) begin
      act_next[req_lvl_reg] = 1'b1;
    end
  end

  always @* begin
    wr_hit = 1'b1;
    case (aw_addr_reg)
      `TLIC_OFF_CTRL,
      `TLIC_OFF_EN,
      `TLIC_OFF_PRIO,
      `TLIC_OFF_PSET,
      `TLIC_OFF_PCLR,
      `TLIC_OFF_IST,
      `TLIC_OFF_IMASK: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always @* begin
    rd_val = 32'h00000000;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `TLIC_OFF_CTRL:  rd_val[`TLIC_CTRL_GEN] = gen_reg;
      `TLIC_OFF_EN:    rd_val[NSRC-1:0] = en_reg;
      `TLIC_OFF_PRIO:  rd_val[NSRC-1:0] = prio_reg;
      `TLIC_OFF_PSET:  rd_val[NSRC-1:0] = pend_reg;
      `TLIC_OFF_PCLR:  rd_val[NSRC-1:0] = pend_reg;
      `TLIC_OFF_STAT:  rd_val[10:0] = stat_word;
      `TLIC_OFF_IST:   rd_val[`TLIC_IST_W-1:0] = ist_reg;
      `TLIC_OFF_IMASK: rd_val[`TLIC_IST_W-1:0] = imask_reg;
      default:         rd_hit = 1'b0;
    endcase
  end

  // Registers and pending flags
  always @(posedge aclk) begin
    if (!aresetn) begin
      gen_reg   <= `TLIC_RST_CTRL;
      en_reg    <= `TLIC_RST_EN;
      prio_reg  <= `TLIC_RST_PRIO;
      pend_reg  <= `TLIC_RST_PEND;
      ist_reg   <= {`TLIC_IST_W{1'b0}};
      imask_reg <= {`TLIC_IST_W{1'b0}};
      act_reg   <= 2'b00;
    end else begin
      pend_reg <= pend_next;
      act_reg  <= act_next;
      ist_reg  <= (ist_reg & ~ist_clr) | ist_set;
      if (wr_go) begin
        case (aw_addr_reg)
          `TLIC_OFF_CTRL: begin
            if (w_strb_reg[0]) begin
              gen_reg <= w_data_reg[`TLIC_CTRL_GEN];
            end
          end
          `TLIC_OFF_EN: begin
            en_reg <= en_merged[NSRC-1:0];
          end
          `TLIC_OFF_PRIO: begin
            prio_reg <= prio_merged[NSRC-1:0];
          end
          `TLIC_OFF_IMASK: begin
            if (w_strb_reg[0]) begin
              imask_reg <= w_data_reg[`TLIC_IST_W-1:0];
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Detect cycle: the winner is registered every clock.
  // Because it lags the enables by one cycle, a request may survive a
  // clearing write for one boundary; software pads such writes.
  always @(posedge aclk) begin
    if (!aresetn) begin
      req_valid_reg <= 1'b0;
      req_idx_reg   <= {`TLIC_IDX_W{1'b0}};
      req_lvl_reg   <= 1'b0;
    end else begin
      req_valid_reg <= (hi_ok & |hi_req) | (lo_ok & |lo_req);
      req_lvl_reg   <= hi_ok & |hi_req;
      if (hi_ok & |hi_req) begin
        req_idx_reg <= tlic_first(hi_req);
      end else begin
        req_idx_reg <= tlic_first(lo_req);
      end
    end
  end

  // Call issue: the long call occupies the CPU for a fixed count
  always @(posedge aclk) begin
    if (!aresetn) begin
      call_start   <= 1'b0;
      call_vector  <= 16'h0000;
      call_source  <= {`TLIC_IDX_W{1'b0}};
      call_level   <= 1'b0;
      call_cnt_reg <= {`TLIC_CNT_W{1'b0}};
    end else begin
      call_start <= take;
      if (take) begin
        // Vectors sit one fixed slot apart, upward from the base
        call_vector  <= `TLIC_VEC_BASE +
                        {{(16-`TLIC_IDX_W){1'b0}}, req_idx_reg} * `TLIC_VEC_STEP;
        call_source  <= req_idx_reg;
        call_level   <= req_lvl_reg;
        call_cnt_reg <= CALL_CNT;
      end else if (call_busy) begin
        call_cnt_reg <= call_cnt_reg - {{(`TLIC_CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // AXI4-Lite write channel; address and data may arrive in either order
  // A new write waits until the last response has drained
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg  <= 1'b0;
      aw_addr_reg  <= {`TLIC_ADDR_W{1'b0}};
      w_full_reg   <= 1'b0;
      w_data_reg   <= 32'h00000000;
      w_strb_reg   <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `TLIC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_full_reg) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= {s_axi_awaddr[`TLIC_ADDR_W-1:2], 2'b00};
      end
      if (s_axi_wvalid && !w_full_reg) begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_full_reg  <= 1'b0;
        w_full_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `TLIC_RESP_OKAY : `TLIC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI4-Lite read channel; data is captured when the address is taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `TLIC_RESP_OKAY;
    end else begin
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_val;
        s_axi_rresp  <= rd_hit ? `TLIC_RESP_OKAY : `TLIC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

/* File: test/tlic_top_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tlic_consts.vh"
module tlic_chk #(
  parameter NSRC = `TLIC_NSRC
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        instr_done,
  input wire logic        interrupt_return_instruction_done,
  input wire logic        call_start,
  input wire logic [15:0] call_vector,
  input wire logic [4:0]  call_source,
  input wire logic        call_level,
  input wire logic        call_busy,
  input wire logic [1:0]  active_level
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_call_boundary: assert property (call_start |-> $past(instr_done && !interrupt_return_instruction_done))
    else $error("call off a plain boundary");
  a_call_length: assert property (call_start |-> call_busy [*4] ##1 !call_busy)
    else $error("long call length wrong");
  a_vector_map: assert property (call_start |->
    call_vector == `TLIC_VEC_BASE + `TLIC_VEC_STEP * call_source)
    else $error("vector does not match source");
  a_source_range: assert property (call_start |-> call_source < NSRC)
    else $error("source out of range");
  a_high_final: assert property (call_start |-> $past(active_level) < 2'h2)
    else $error("high routine preempted");
  a_equal_waits: assert property (call_start && !call_level |-> $past(active_level) == 2'h0)
    else $error("low call while routine active");
  a_level_mark: assert property (call_start |->
    active_level == ($past(active_level) | (2'h1 << call_level)))
    else $error("level not marked");
  a_return_pop: assert property (instr_done && interrupt_return_instruction_done && active_level != 2'h0 |=>
    active_level == {1'h0, $past(active_level) == 2'h3})
    else $error("return did not clear top level");
endmodule
bind tlic_top tlic_chk #(.NSRC(NSRC)) tlic_chk_i (.aclk, .aresetn, .instr_done, .interrupt_return_instruction_done,
  .call_start, .call_vector, .call_source, .call_level, .call_busy, .active_level);
`default_nettype wire

/* File: test/tlic_cpu.sv */
`timescale 1ns/1ps
`default_nettype none
module tlic_cpu (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       call_busy,
  input  wire logic [3:0] gap,
  input  wire logic       ret_go,
  output var  logic       instr_done,
  output var  logic       interrupt_return_instruction_done
);
  logic [3:0] cnt_reg;
  logic       ret_pend_reg;
  // No boundary inside the long call, bar one in its first cycle when gap is 0; gap sets a prompt or slow pace
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= 4'h0;
      ret_pend_reg <= 1'h0;
      instr_done <= 1'h0;
      interrupt_return_instruction_done <= 1'h0;
    end else begin
      instr_done <= 1'h0;
      interrupt_return_instruction_done <= 1'h0;
      if (call_busy) begin
        cnt_reg <= gap;
      end else if (cnt_reg != 4'h0) begin
        cnt_reg <= cnt_reg - 4'h1;
      end else begin
        instr_done <= 1'h1;
        interrupt_return_instruction_done <= ret_pend_reg;
        ret_pend_reg <= 1'h0;
        cnt_reg <= gap;
      end
      if (ret_go)
        ret_pend_reg <= 1'h1;
    end
  end
endmodule
`default_nettype wire

/* File: test/tlic_top_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tlic_consts.vh"
module tlic_top_test;
  logic        aclk = 1'h0;
  logic        aresetn = 1'h0;
  logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, ret_go = 1'h0;
  logic [17:0] src_event = 18'h0;
  logic [3:0]  gap = 4'h3;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]   s_axi_bresp, s_axi_rresp, active_level;
  wire [31:0]  s_axi_rdata;
  wire         instr_done, interrupt_return_instruction_done, call_start, call_level, call_busy, global_irq_enable, irq;
  wire [15:0]  call_vector;
  wire [4:0]   call_source;
  int          fails = 0, num_checks = 0, ncall = 0, since = 0, lag = 0, cyc = 0;
  tlic_top tlic_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .src_event, .instr_done, .interrupt_return_instruction_done, .call_start,
    .call_vector, .call_source, .call_level, .call_busy, .active_level, .global_irq_enable, .irq);
  tlic_cpu tlic_cpu_i (.aclk, .aresetn, .call_busy, .gap, .ret_go, .instr_done, .interrupt_return_instruction_done);
  initial forever #4 aclk = ~aclk;
  // Count calls and instructions since the last return
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (instr_done)
      since <= interrupt_return_instruction_done ? 0 : since + 1;
    if (call_start) begin
      ncall <= ncall + 1;
      lag <= since;
    end
    if (cyc == 20000) begin
      fails++;
      close_out();
    end
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    chk("bresp", s_axi_bresp, er);
  endtask
  task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    chk("rdata", s_axi_rdata, e);
    chk("rresp", s_axi_rresp, er);
  endtask
  task automatic waitc(input int n);
    repeat (200) if (ncall < n) @(posedge aclk);
    chk("calls", ncall, n);
  endtask
  task automatic quiet();
    int n0;
    n0 = ncall;
    repeat (30) @(posedge aclk);
    chk("calls", ncall, n0);
  endtask
  // Routine tail: clear the flag, then return
  task automatic fin(input logic [31:0] v);
    axw(`TLIC_OFF_PCLR, v, 2'h0);
    ret_go <= 1'h1;
    @(posedge aclk);
    ret_go <= 1'h0;
    do @(posedge aclk); while (!(instr_done && interrupt_return_instruction_done));
    @(posedge aclk);
  endtask
  task automatic close_out();
    if (fails == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    axr(`TLIC_OFF_CTRL, 32'h0, 2'h0);
    axr(`TLIC_OFF_EN, 32'h0, 2'h0);
    axr(`TLIC_OFF_PRIO, 32'h0, 2'h0);
    axr(8'h20, 32'h0, `TLIC_RESP_SLVERR);
    axw(8'h20, 32'h1, `TLIC_RESP_SLVERR);
    src_event <= 18'h00020;
    @(posedge aclk);
    src_event <= 18'h0;
    axw(`TLIC_OFF_EN, 32'h20, 2'h0);
    quiet();
    axr(`TLIC_OFF_PSET, 32'h20, 2'h0);
    // A bus write outlasts any one-cycle pad the far side would need
    axw(`TLIC_OFF_EN, 32'h0, 2'h0);
    axw(`TLIC_OFF_CTRL, 32'h1, 2'h0);
    chk("gen", global_irq_enable, 1'h1);
    quiet();
    axw(`TLIC_OFF_PCLR, 32'h20, 2'h0);
    gap <= 4'h0;
    axw(`TLIC_OFF_EN, 32'h3FFFF, 2'h0);
    for (int i = 0; i < 18; i++) begin
      axw(`TLIC_OFF_PSET, 32'h1 << i, 2'h0);
      waitc(i + 1);
      chk("src", call_source, i);
      chk("vec", call_vector, `TLIC_VEC_BASE + `TLIC_VEC_STEP * i);
      axr(`TLIC_OFF_PSET, ((`TLIC_HWCLR_MASK >> i) & 1) ? 0 : 32'h1 << i, 2'h0);
      fin(32'h1 << i);
    end
    chk("act", active_level, 2'h0);
    chk("irq", irq, 1'h0);
    axw(`TLIC_OFF_IMASK, 32'h1, 2'h0);
    chk("irq", irq, 1'h1);
    axw(`TLIC_OFF_IST, 32'h3, 2'h0);
    chk("irq", irq, 1'h0);
    gap <= 4'h3;
    axw(`TLIC_OFF_PSET, 32'h40, 2'h0);
    waitc(19);
    axr(`TLIC_OFF_IST, 32'h1, 2'h0);
    axr(`TLIC_OFF_IMASK, 32'h1, 2'h0);
    fin(32'h0);
    waitc(20);
    chk("lag", lag, 1);
    chk("irq", irq, 1'h1);
    fin(32'h40);
    axw(`TLIC_OFF_PRIO, 32'h1000, 2'h0);
    axw(`TLIC_OFF_PSET, 32'h1280, 2'h0);
    waitc(21);
    chk("src", call_source, 12);
    quiet();
    fin(32'h1000);
    waitc(22);
    chk("src", call_source, 7);
    axw(`TLIC_OFF_PSET, 32'h1000, 2'h0);
    waitc(23);
    chk("lvl", call_level, 1'h1);
    chk("act", active_level, 2'h3);
    fin(32'h1000);
    quiet();
    chk("act", active_level, 2'h1);
    fin(32'h80);
    waitc(24);
    chk("src", call_source, 9);
    fin(32'h200);
    close_out();
  end
endmodule
`default_nettype wire
